// ---- dv/nv_program_control_checker.sv ----
// Port checker for the programming control block
// Assumes: one clock, synchronous active-low reset, RC_DIV of at least 2
`timescale 1ns/1ns
`include "nv_program_control_map.vh"
module nv_program_control_checker (
	input wire        MCLK_I,
	input wire        RSTN_I,
	input wire [17:0] AVS_ADDRESS_I,
	input wire        AVS_READ_I,
	input wire        AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0]  AVS_BYTEENABLE_I,
	input wire [31:0] AVS_READDATA_O,
	input wire        AVS_WAITREQUEST_O,
	input wire        PUMP_CLOCK_SELECT_I,
	input wire        PUMP_TICK_O,
	input wire        EPROM_HV_O,
	input wire        GATE_STRESS_O,
	input wire        DRAIN_STRESS_O,
	input wire        EEPROM_HV_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	wire req = AVS_READ_I || AVS_WRITE_I;
	wire acc = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
	wire ee_on = acc && AVS_ADDRESS_I[17:2] == `NVPC_IDX && AVS_WRITEDATA_I[1:0] == 2'b11;
	wire ep_on = acc && AVS_ADDRESS_I[17:2] == `EPC_IDX && AVS_WRITEDATA_I[0];
	////////////////////////////////////////////////////////////////////////////////
	property p_wait_lat;
		$rose(req) |-> AVS_WAITREQUEST_O [*2] ##1 !AVS_WAITREQUEST_O;
	endproperty
	a_wait_lat: assert property (p_wait_lat) else $error("answer not two cycles late");
	property p_wait_one;
		!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
	property p_rdata;
		!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h000000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("upper read data not zero");
	// Three cycles of select so the registered tick has caught up
	property p_pump_e;
		!PUMP_CLOCK_SELECT_I [*3] |-> PUMP_TICK_O;
	endproperty
	a_pump_e: assert property (p_pump_e) else $error("pump tick low on E clock");
	property p_pump_rc;
		PUMP_CLOCK_SELECT_I [*3] ##0 PUMP_TICK_O |=> !PUMP_TICK_O;
	endproperty
	a_pump_rc: assert property (p_pump_rc) else $error("oscillator tick too wide");
	property p_stress;
		!(GATE_STRESS_O && DRAIN_STRESS_O);
	endproperty
	a_stress: assert property (p_stress) else $error("both stress modes on");
	property p_ee_hv;
		$rose(EEPROM_HV_O) |-> $past(ee_on) || $past(ee_on, 2);
	endproperty
	a_ee_hv: assert property (p_ee_hv) else $error("EEPROM voltage without enable");
	property p_ep_hv;
		$rose(EPROM_HV_O) |-> $past(ep_on) || $past(ep_on, 2);
	endproperty
	a_ep_hv: assert property (p_ep_hv) else $error("EPROM voltage without enable");
	c_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
	c_ee: cover property ($rose(EEPROM_HV_O));
	c_ep: cover property ($rose(EPROM_HV_O));
endmodule // nv_program_control_checker
bind nv_program_control nv_program_control_checker u_chk (
	.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
	.AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PUMP_CLOCK_SELECT_I(PUMP_CLOCK_SELECT_I),
	.PUMP_TICK_O(PUMP_TICK_O), .EPROM_HV_O(EPROM_HV_O), .GATE_STRESS_O(GATE_STRESS_O),
	.DRAIN_STRESS_O(DRAIN_STRESS_O), .EEPROM_HV_O(EEPROM_HV_O));

// ---- dv/testbench.sv ----
// Self-checking bench for the programming control block, separate EPROM register
// Assumes: the register map header is on the include path
`timescale 1ns/1ns
`include "nv_program_control_map.vh"
module testbench;
	reg         clk, rstn, rd, wr, special, hvpin, psel;
	reg  [17:0] addr;
	reg  [31:0] wdata;
	reg  [3:0]  be;
	reg  [7:0]  ep_rd;
	wire [31:0] rdat;
	wire        wreq, arr_en, ep_hv, gate, drain, ee_hv, tick;
	wire [13:0] ep_addr;
	wire [7:0]  ep_wdata, cfg;
	reg  [31:0] got;
	reg  [13:0] seen_addr;
	reg         hv_seen;
	integer     mismatches, checks, i, n;
	nv_program_control #(.SEPARATE_EPROM(1), .RC_DIV(8)) DUT (
		.MCLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .SPECIAL_MODE_I(special),
		.HIGH_VOLTAGE_INPUT_PIN_I(hvpin), .PUMP_CLOCK_SELECT_I(psel),
		.EPROM_RDATA_I(ep_rd), .EPROM_ADDR_O(ep_addr), .EPROM_WDATA_O(ep_wdata),
		.EPROM_ARRAY_EN_O(arr_en), .EPROM_HV_O(ep_hv), .GATE_STRESS_O(gate),
		.DRAIN_STRESS_O(drain), .EEPROM_HV_O(ee_hv), .PUMP_TICK_O(tick), .CONFIG_O(cfg));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				mismatches = mismatches + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// One bus cycle; the request stands until waitrequest is sampled low
	// Only the watchdog ends a wait that never gets its answer
	task bus(input w, input [15:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= {a, 2'b00};
			wdata <= {24'h000000, d};
			wr <= w;
			rd <= !w;
			@(posedge clk);
			while (wreq !== 1'b0)
				@(posedge clk);
			got = rdat;
			seen_addr = ep_addr;
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	task w8(input [15:0] a, input [7:0] d);
		bus(1'b1, a, d);
	endtask
	task r8(input [15:0] a, input [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			chk(got, {24'h000000, e});
		end
	endtask
	task prog(input [15:0] a, input [7:0] d);
		begin
			w8(`NVPC_IDX, 8'h02);
			w8(a, d);
			w8(`NVPC_IDX, 8'h03);
			repeat (2) @(posedge clk);
			hv_seen = ee_hv;
			w8(`NVPC_IDX, 8'h00);
		end
	endtask
	task test_done;
		begin
			$display("checks=%0d mismatches=%0d", checks, mismatches);
			if (mismatches == 0 && checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Runs first: the protect bits must be cleared inside the early window
	task t_reset;
		begin
			r8(`NVPC_IDX, `NVPC_RESET);
			r8(`EPC_IDX, `EPC_RESET);
			r8(`EBP_IDX, {3'b000, `EBP_RESET});
			r8(16'h1000, 8'h00);
			w8(`EBP_IDX, 8'h00);
			r8(`EBP_IDX, 8'h00);
		end
	endtask
	task t_eeprom;
		begin
			w8(`NVPC_IDX, 8'h01);
			r8(`NVPC_IDX, 8'h00);
			w8(`NVPC_IDX, 8'h03);
			r8(`NVPC_IDX, 8'h00);
			w8(`NVPC_IDX, 8'h02);
			r8(`EE_BASE, `LOCKED_READ);
			w8(`NVPC_IDX, 8'h03);
			repeat (2) @(posedge clk);
			chk(ee_hv, 1'b0);
			w8(`NVPC_IDX, 8'h00);
			prog(`EE_BASE, 8'ha5);
			chk(hv_seen, 1'b1);
			r8(`EE_BASE, 8'ha5);
			prog(`EE_BASE, 8'hf0);
			r8(`EE_BASE, 8'ha0);
		end
	endtask
	task t_protect;
		begin
			w8(`EBP_IDX, 8'h01);
			r8(`EBP_IDX, 8'h01);
			w8(`EBP_IDX, 8'h00);
			r8(`EBP_IDX, 8'h01);
			prog(16'hb61f, 8'h00);
			r8(16'hb61f, `ERASED_BYTE);
			prog(16'hb620, 8'h0f);
			r8(16'hb620, 8'h0f);
			w8(`EBP_IDX, 8'hf0);
			r8(`EBP_IDX, 8'h11);
			prog(`CFG_IDX, 8'h00);
			chk(cfg, `ERASED_BYTE);
		end
	endtask
	task t_eprom;
		begin
			w8(`EPC_IDX, 8'h01);
			r8(`EPC_IDX, 8'h00);
			r8(16'hc000, 8'h77);
			w8(`EPC_IDX, 8'h20);
			r8(16'hc000, `LOCKED_READ);
			w8(16'hc045, 8'h3c);
			// Address output lags the latch by one more register stage
			repeat (2) @(posedge clk);
			chk(ep_wdata, 8'h3c);
			chk(ep_addr, 14'h0045);
			w8(`EPC_IDX, 8'h21);
			repeat (2) @(posedge clk);
			chk(ep_hv, 1'b1);
			w8(`EPC_IDX, 8'h01);
			r8(`EPC_IDX, 8'h21);
			w8(`EPC_IDX, 8'h00);
			r8(`EPC_IDX, 8'h20);
			w8(`EPC_IDX, 8'h00);
			r8(`EPC_IDX, 8'h00);
		end
	endtask
	task t_special;
		begin
			w8(`EPC_IDX, 8'h9e);
			r8(`EPC_IDX, 8'h00);
			chk({gate, drain}, 2'b00);
			special <= 1'b1;
			repeat (4) @(posedge clk);
			for (i = 0; i < 4; i = i + 1)
			begin
				w8(`EPC_IDX, i << 1);
				repeat (2) @(posedge clk);
				chk({gate, drain}, (i == 2) ? 2'b10 : (i == 3) ? 2'b01 : 2'b00);
				r8(`EPC_IDX, i << 1);
			end
			w8(`EPC_IDX, 8'h08);
			bus(1'b0, 16'hff12, 8'h00);
			chk(seen_addr[7:0], 8'h12);
			chk(arr_en, 1'b0);
			w8(`EPC_IDX, 8'h10);
			bus(1'b0, 16'hc3ff, 8'h00);
			chk(seen_addr[13:5], 9'h01f);
			w8(`EPC_IDX, 8'ha0);
			r8(`EPC_IDX, 8'ha0);
			w8(16'hc065, 8'h5a);
			repeat (2) @(posedge clk);
			chk(ep_addr, 14'h0045);
			chk(ep_wdata, 8'h5a);
			w8(`EBP_IDX, 8'h00);
			r8(`EBP_IDX, 8'h00);
			w8(`EPC_IDX, 8'h00);
			special <= 1'b0;
		end
	endtask
	task t_pump;
		begin
			psel <= 1'b1;
			repeat (4) @(posedge clk);
			n = 0;
			repeat (16)
			begin
				@(posedge clk);
				n = n + tick;
			end
			chk(n, 2);
			psel <= 1'b0;
			repeat (4) @(posedge clk);
			chk(tick, 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Whole run is a few hundred cycles; this only catches a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches = mismatches + 1;
		test_done;
	end
	initial
	begin
		mismatches = 0;
		checks = 0;
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 18'h00000;
		wdata = 32'h00000000;
		be = 4'hf;
		special = 1'b0;
		hvpin = 1'b1;
		psel = 1'b0;
		ep_rd = 8'h77;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_eeprom;
		repeat (64) @(posedge clk);
		t_protect;
		t_eprom;
		t_special;
		t_pump;
		test_done;
	end
endmodule // testbench

// ---- logic/nv_program_control.v ----
// Programming control for on-chip EPROM and EEPROM, with block protect
// Assumes: Avalon-MM master on MCLK_I; EPROM array outside, EEPROM model inside
//
// What this block does
// [RL1] EPROM latch set: EPROM writes capture address and data, reads hide array
// [RL2] EPROM latch always readable; its writes ignored while voltage enable is set
// [RL3] Combined voltage enable writable only while either latch is set
// [RL4] EPROM and EEPROM latch bits are never both set
// [RL5] Separate EPROM voltage enable writable only while EPROM latch is set
// [RL6] Multi-byte enable makes address bit 5 a don't care when programming
// [RL7] Multi-byte enable written only in special modes, reads 0 in normal
// [RL8] Extra columns: user array off, address bits 13:5 used, 4:0 ignored
// [RL9] Extra rows: user array off, address bits 7:0 used, 13:8 ignored
// [RL10] Extra column and row selects special-mode only, read 0 in normal
// [RL11] Test select: 00 normal, 01 reserved, 10 gate, 11 drain; special only
// [RL12] EEPROM erased bits read 1; programming only turns ones into zeros
// [RL13] EEPROM reads like ROM with latch clear; interlocks guard the sequence
// [RL14] Pump clock is E clock when select is 0, RC oscillator when 1
// [RL15] EEPROM voltage needs latch write, then data write, then enable write
// [RL16] A write setting EEPROM latch and enable together leaves both clear
// [RL17] Protect bits reset to 1; clearable only in first 64 cycles normally
// [RL18] Protect bits accept ones any time; special modes lift write-once
// [RL19] Config protect set blocks programming of the config register
// [RL20] Four protect bits guard blocks of 32, 64, 128 and 288 bytes
// [RL21] Software sets latch, writes data, sets enable, waits 2-4 ms, clears
// [RL22] Protect register bits 7:5 read 0
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "nv_program_control_map.vh"

module nv_program_control #(
	parameter SEPARATE_EPROM = 0,
	parameter RC_DIV         = 8
) (
	input  wire        MCLK_I,
	input  wire        RSTN_I,
	input  wire [17:0] AVS_ADDRESS_I,
	input  wire        AVS_READ_I,
	input  wire        AVS_WRITE_I,
	input  wire [31:0] AVS_WRITEDATA_I,
	input  wire [3:0]  AVS_BYTEENABLE_I,
	output reg  [31:0] AVS_READDATA_O,
	output reg         AVS_WAITREQUEST_O,
	input  wire        SPECIAL_MODE_I,
	input  wire        HIGH_VOLTAGE_INPUT_PIN_I,
	input  wire        PUMP_CLOCK_SELECT_I,
	input  wire [7:0]  EPROM_RDATA_I,
	output reg  [13:0] EPROM_ADDR_O,
	output reg  [7:0]  EPROM_WDATA_O,
	output reg         EPROM_ARRAY_EN_O,
	output reg         EPROM_HV_O,
	output reg         GATE_STRESS_O,
	output reg         DRAIN_STRESS_O,
	output reg         EEPROM_HV_O,
	output reg         PUMP_TICK_O,
	output reg  [7:0]  CONFIG_O
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function blk_protected;
	input [8:0] off;
	input [3:0] bits;
	begin
		if (off < `BLK0_END)
			blk_protected = bits[0];
		else if (off < `BLK1_END)
			blk_protected = bits[1];
		else if (off < `BLK2_END)
			blk_protected = bits[2];
		else
			blk_protected = bits[3];
	end
endfunction

function [13:0] ep_map;
	input [13:0] a;
	input        col;
	input        row;
	input        multi_byte_enable;
	begin
		if (col)
			ep_map = {a[13:5], 5'h00}; // RL8
		else if (row)
			ep_map = {6'h00, a[7:0]}; // RL9
		else if (multi_byte_enable)
			ep_map = {a[13:6], 1'b0, a[4:0]}; // RL6
		else
			ep_map = a;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg        mode_m_q;
reg        special_q;
reg        vpp_m_q;
reg        vpp_q;
reg [1:0]  ph_q;
reg        ep_latch_q;
reg        ee_latch_q;
reg        pv_en_q;
reg [4:0]  misc_q;
reg        ep_hv_q;
reg        multi_q;
reg        col_sel_q;
reg        row_sel_q;
reg [1:0]  tsel_q;
reg [4:0]  bp_q;
reg [6:0]  bp_cnt_q;
reg [13:0] lat_addr_q;
reg        ee_loaded_q;
reg        ee_cfg_q;
reg [8:0]  ee_addr_q;
reg [7:0]  ee_data_q;
reg [7:0]  config_q;
reg [3:0]  rc_cnt_q;
reg [7:0]  ee_mem [0:511];

integer i;

// Nonvolatile cells start erased in simulation
initial
begin
	for (i = 0; i < 512; i = i + 1)
		ee_mem[i] = `ERASED_BYTE; // RL12
	config_q = `ERASED_BYTE;
end

////////////////////////////////////////////////////////////////////////////////
// Decode

wire [15:0] idx      = AVS_ADDRESS_I[17:2];
wire [7:0]  wd       = AVS_WRITEDATA_I[7:0];
wire        hit_nvpc = (idx == `NVPC_IDX);
wire        hit_epc  = (idx == `EPC_IDX) && (SEPARATE_EPROM != 0);
wire        hit_ebp  = (idx == `EBP_IDX);
wire        hit_cfg  = (idx == `CFG_IDX);
wire        hit_ee   = (idx >= `EE_BASE) && (idx <= `EE_LAST);
wire        hit_ep   = (idx[15:14] == `EP_TOP);
wire [15:0] ee_rel   = idx - `EE_BASE;
wire [8:0]  ee_off   = ee_rel[8:0];
wire [7:0]  nvpc_rst = `NVPC_RESET;
wire [7:0]  epc_rst  = `EPC_RESET;
wire        do_wr    = (ph_q == 2'd2) && AVS_WRITE_I && AVS_BYTEENABLE_I[0];
wire        sep      = (SEPARATE_EPROM != 0);
wire        ep_hv_on = sep ? ep_hv_q : pv_en_q;
wire        bp_open  = (bp_cnt_q < `EBP_WINDOW);
wire        x_col    = special_q & col_sel_q;
wire        x_row    = special_q & row_sel_q;
wire        x_multi  = special_q & multi_q;

////////////////////////////////////////////////////////////////////////////////
// Combined control register write: next values

reg ep_latch_n;
reg ee_latch_n;
reg pv_en_n;

always @*
begin
	ep_latch_n = ep_latch_q;
	ee_latch_n = wd[`NVPC_EE_LATCH];
	pv_en_n    = pv_en_q;
	if (!sep && !ep_hv_on)
		ep_latch_n = wd[`NVPC_EP_LATCH]; // RL2
	if (ep_latch_n && ee_latch_n)
	begin
		ep_latch_n = ep_latch_q; // RL4
		ee_latch_n = ee_latch_q; // RL4
	end
	if (ep_latch_q || ee_latch_q)
		pv_en_n = wd[`NVPC_PGMV] & ((ep_latch_q & ~sep) | ee_loaded_q); // RL3 RL15
	if (wd[`NVPC_EE_LATCH] && wd[`NVPC_PGMV] && !ee_latch_q)
	begin
		ee_latch_n = 1'b0; // RL16
		pv_en_n    = 1'b0; // RL16
	end
end

wire ee_fire = do_wr && hit_nvpc && ee_latch_q && ee_latch_n && pv_en_n && !pv_en_q
	&& !misc_q[0];

////////////////////////////////////////////////////////////////////////////////
// Read mux

reg [7:0] rd_d;

always @*
begin
	rd_d = 8'h00;
	if (hit_nvpc)
		rd_d = {misc_q[4:3], ep_latch_q & ~sep, misc_q[2:1], misc_q[0],
			ee_latch_q, pv_en_q};
	else if (hit_epc)
		rd_d = {x_multi, 1'b0, ep_latch_q, x_col, x_row,
			tsel_q & {2{special_q}}, ep_hv_q}; // RL7 RL10 RL11
	else if (hit_ebp)
		rd_d = {3'b000, bp_q}; // RL22
	else if (hit_cfg)
		rd_d = ee_latch_q ? `LOCKED_READ : config_q; // RL13
	else if (hit_ee)
		rd_d = ee_latch_q ? `LOCKED_READ : ee_mem[ee_off]; // RL13
	else if (hit_ep)
		rd_d = ep_latch_q ? `LOCKED_READ : EPROM_RDATA_I; // RL1
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave: request seen, array fetched, answered with waitrequest low

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		ph_q              <= 2'd0;
		AVS_WAITREQUEST_O <= 1'b1;
		AVS_READDATA_O    <= 32'h00000000;
	end
	else
	begin
		case (ph_q)
			2'd0:
			begin
				if (AVS_READ_I || AVS_WRITE_I)
					ph_q <= 2'd1;
			end
			2'd1:
			begin
				AVS_READDATA_O    <= {24'h000000, rd_d};
				AVS_WAITREQUEST_O <= 1'b0;
				ph_q              <= 2'd2;
			end
			2'd2:
			begin
				AVS_WAITREQUEST_O <= 1'b1;
				ph_q              <= 2'd0;
			end
			default:
				ph_q <= 2'd0;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for mode strap and programming voltage pin

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		mode_m_q  <= 1'b0;
		special_q <= 1'b0;
		vpp_m_q   <= 1'b0;
		vpp_q     <= 1'b0;
	end
	else
	begin
		mode_m_q  <= SPECIAL_MODE_I;
		special_q <= mode_m_q;
		vpp_m_q   <= HIGH_VOLTAGE_INPUT_PIN_I;
		vpp_q     <= vpp_m_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		ep_latch_q  <= nvpc_rst[`NVPC_EP_LATCH];
		ee_latch_q  <= nvpc_rst[`NVPC_EE_LATCH];
		pv_en_q     <= nvpc_rst[`NVPC_PGMV];
		misc_q      <= 5'h00;
		ep_hv_q     <= epc_rst[`EPC_HV_EN];
		multi_q     <= 1'b0;
		col_sel_q   <= 1'b0;
		row_sel_q   <= 1'b0;
		tsel_q      <= 2'b00;
		ee_loaded_q <= 1'b0;
	end
	else if (do_wr && hit_nvpc)
	begin
		ep_latch_q <= ep_latch_n;
		ee_latch_q <= ee_latch_n;
		pv_en_q    <= pv_en_n;
		misc_q     <= {wd[`NVPC_ODD], wd[`NVPC_EVEN], wd[`NVPC_BYTE], wd[`NVPC_ROW],
			wd[`NVPC_ERASE]};
		if (!ee_latch_n)
			ee_loaded_q <= 1'b0; // RL15
	end
	else if (do_wr && hit_epc)
	begin
		if (!ep_hv_q)
			ep_latch_q <= wd[`EPC_EP_LATCH] & ~ee_latch_q; // RL2 RL4
		if (ep_latch_q)
			ep_hv_q <= wd[`EPC_HV_EN]; // RL5
		if (special_q)
		begin
			multi_q   <= wd[`EPC_MULTI]; // RL7
			col_sel_q <= wd[`EPC_COL_SEL]; // RL10
			row_sel_q <= wd[`EPC_ROW_SEL]; // RL10
			tsel_q    <= {wd[`EPC_T_HI], wd[`EPC_T_LO]}; // RL11
		end
	end
	else if (do_wr && (hit_ee || hit_cfg) && ee_latch_q && !pv_en_q)
		ee_loaded_q <= 1'b1; // RL15
end

////////////////////////////////////////////////////////////////////////////////
// Programming latches and EEPROM cells

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		lat_addr_q    <= 14'h0000;
		EPROM_WDATA_O <= 8'h00;
		ee_cfg_q      <= 1'b0;
		ee_addr_q     <= 9'h000;
		ee_data_q     <= 8'h00;
	end
	else
	begin
		if (do_wr && hit_ep && ep_latch_q)
		begin
			lat_addr_q    <= idx[13:0]; // RL1
			EPROM_WDATA_O <= wd; // RL1
		end
		if (do_wr && (hit_ee || hit_cfg) && ee_latch_q && !pv_en_q)
		begin
			ee_cfg_q  <= hit_cfg;
			ee_addr_q <= ee_off;
			ee_data_q <= wd;
		end
	end
end

// Cell change is applied at voltage switch-on; pulse length is software's job
always @(posedge MCLK_I)
begin
	if (ee_fire && ee_cfg_q && !bp_q[4])
		config_q <= config_q & ee_data_q; // RL19 RL12
	if (ee_fire && !ee_cfg_q && !blk_protected(ee_addr_q, bp_q[3:0]))
		ee_mem[ee_addr_q] <= ee_mem[ee_addr_q] & ee_data_q; // RL20 RL12
end

////////////////////////////////////////////////////////////////////////////////
// Block protect with write-once window after reset

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		bp_q     <= `EBP_RESET; // RL17
		bp_cnt_q <= 7'd0;
	end
	else
	begin
		if (bp_open)
			bp_cnt_q <= bp_cnt_q + 7'd1; // RL17
		if (do_wr && hit_ebp)
		begin
			if (special_q || bp_open)
				bp_q <= wd[4:0]; // RL17 RL18
			else
				bp_q <= bp_q | wd[4:0]; // RL18
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pump clock: E clock or divided RC stand-in, as an enable pulse

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		rc_cnt_q    <= 4'h0;
		PUMP_TICK_O <= 1'b0;
	end
	else
	begin
		if (rc_cnt_q == RC_DIV[3:0] - 4'h1)
			rc_cnt_q <= 4'h0;
		else
			rc_cnt_q <= rc_cnt_q + 4'h1;
		PUMP_TICK_O <= PUMP_CLOCK_SELECT_I ? (rc_cnt_q == 4'h0) : 1'b1; // RL14
	end
end

////////////////////////////////////////////////////////////////////////////////
// Array-side outputs

always @(posedge MCLK_I)
begin
	if (!RSTN_I)
	begin
		EPROM_ADDR_O     <= 14'h0000;
		EPROM_ARRAY_EN_O <= 1'b1;
		EPROM_HV_O       <= 1'b0;
		EEPROM_HV_O      <= 1'b0;
		GATE_STRESS_O    <= 1'b0;
		DRAIN_STRESS_O   <= 1'b0;
		CONFIG_O         <= `ERASED_BYTE;
	end
	else
	begin
		EPROM_ADDR_O     <= ep_map(ep_latch_q ? lat_addr_q : idx[13:0], x_col, x_row,
			x_multi & ep_latch_q);
		EPROM_ARRAY_EN_O <= ~(x_col | x_row); // RL8 RL9
		// External supply must be present as well as the enable
		EPROM_HV_O       <= ep_hv_on & ep_latch_q & vpp_q; // RL3 RL5
		EEPROM_HV_O      <= pv_en_q & ee_latch_q; // RL15
		GATE_STRESS_O    <= special_q && (tsel_q == `TSEL_GATE); // RL11
		DRAIN_STRESS_O   <= special_q && (tsel_q == `TSEL_DRAIN); // RL11
		CONFIG_O         <= config_q;
	end
end

endmodule // nv_program_control

// ---- logic/nv_program_control_map.vh ----
// Register indices, field positions, reset values and timing counts
// Assumes: included by the programming control logic, its checker and its testbench
`ifndef NV_PROGRAM_CONTROL_MAP_VH
`define NV_PROGRAM_CONTROL_MAP_VH
// Register indices (byte address is four times the index)
`define EPC_IDX      16'h1036
`define NVPC_IDX     16'h103b
`define EBP_IDX      16'h1030
`define CFG_IDX      16'h103f
// Array windows in the index space
`define EE_BASE      16'hb600
`define EE_LAST      16'hb7ff
`define EP_TOP       2'b11
// Combined control register fields
`define NVPC_ODD     7
`define NVPC_EVEN    6
`define NVPC_EP_LATCH 5
`define NVPC_BYTE    4
`define NVPC_ROW     3
`define NVPC_ERASE   2
`define NVPC_EE_LATCH 1
`define NVPC_PGMV    0
// Separate EPROM control register fields
`define EPC_MULTI    7
`define EPC_EP_LATCH 5
`define EPC_COL_SEL  4
`define EPC_ROW_SEL  3
`define EPC_T_HI     2
`define EPC_T_LO     1
`define EPC_HV_EN    0
// Test select codes
`define TSEL_GATE    2'b10
`define TSEL_DRAIN   2'b11
// Reset, erased and locked-read values
`define NVPC_RESET   8'h00
`define EPC_RESET    8'h00
`define EBP_RESET    5'h1f
`define ERASED_BYTE  8'hff
`define LOCKED_READ  8'h00
// Block protect window and block ends (offsets into the array)
`define EBP_WINDOW   7'd64
`define BLK0_END     9'd32
`define BLK1_END     9'd96
`define BLK2_END     9'd224
`endif
